// >>> core/ssif_pkg.sv
package ssif_pkg;

  // Clock rate and input noise filter time.
  localparam int CLK_PERIOD_NS = 100;
  localparam int FILTER_TIME_NS = 500;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] OFS_SYNC_MODE = 8'h00;
  localparam logic [7:0] OFS_FUNC_LATCH_TRIGGER_INPUT_2 = 8'h04;
  localparam logic [7:0] OFS_OT_DISABLE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFS_TERM_BASE = 8'h20;

  // Field positions.
  localparam int SYNC_FULL_BIT = 1;
  localparam int LATCH_TRIGGER_INPUT_2_OT_MUTE_BIT = 2;
  localparam int LATCH_TRIGGER_INPUT_2_OT_SWAP_BIT = 3;
  localparam int LATCH_TRIGGER_INPUT_2_OT_INV_BIT = 6;
  localparam int LATCH_TRIGGER_INPUT_2_SHARED_SEL_BIT = 8;
  localparam int TERM_FN_W = 4;
  localparam int TERM_INV_BIT = 12;
  localparam int TERM_W = 13;
  localparam int N_MODES = 3;

  // Reset values.
  localparam logic [15:0] SYNC_MODE_RST = 16'h0000;
  localparam logic [15:0] FUNC_LATCH_TRIGGER_INPUT_2_RST = 16'h0000;
  localparam logic OT_DISABLE_RST = 1'b0;
  localparam logic [12:0] TERM_RST = 13'h0000;

  // Interrupt status bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_ALLOC1 = 0;
  localparam int IRQ_ALLOC2 = 1;
  localparam int IRQ_SYNC = 2;

  // Input function codes held in a terminal assignment.
  localparam int N_FN = 14;
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_SMON1 = 4'h1;
  localparam logic [3:0] FN_LATCH1 = 4'h6;
  localparam logic [3:0] FN_EXT_ON = 4'h9;
  localparam logic [3:0] FN_ESTOP = 4'ha;
  localparam logic [3:0] FN_ORIGIN = 4'hb;
  localparam logic [3:0] FN_POS_OT = 4'hc;
  localparam logic [3:0] FN_NEG_OT = 4'hd;

  // Drive conditions presented by the surrounding servo logic.
  typedef struct packed {
    logic mains_ok;
    logic alarm_active;
    logic servo_synced;
    logic ratio_one;
    logic reset_busy;
    logic attr_c_mode;
    logic pos_gen_active;
    logic mains_loss_alarm;
  } ssif_drive_t;

  // Status carried in one response frame.
  typedef struct packed {
    logic ready;
    logic shared;
    logic [7:0] inputs;
  } ssif_resp_t;

endpackage : ssif_pkg

// >>> core/ssif_flags.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module ssif_flags #(
  parameter int N_TERM = 8,
  parameter int CNT_W = 8,
  parameter int FILT = ssif_pkg::FILTER_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals and drive state.
  input wire logic [N_TERM-1:0] term_in,
  input wire logic [1:0] ctrl_mode,
  input wire ssif_pkg::ssif_drive_t drive,
  // Communication cycle.
  input wire logic cyc_tick,
  input wire logic [CNT_W-1:0] sync_cycle_counter,
  output ssif_pkg::ssif_resp_t resp,
  output logic resp_valid,
  // Interrupt.
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (N_TERM != 8)
  begin : g_bad_term
    $error("ssif_flags serves exactly eight terminals.");
  end
  if (FILT < 1 || FILT > 255)
  begin : g_bad_filt
    $error("ssif_flags filter length must be 1 to 255.");
  end
  if (CNT_W < 2)
  begin : g_bad_cnt
    $error("ssif_flags counter width must be at least 2.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [15:0] sync_mode_setting_reg;
  logic [15:0] function_extended_setting_two_reg;
  logic overtravel_function_disable_reg;
  logic [ssif_pkg::TERM_W-1:0] term_cfg_reg [N_TERM];
  logic [ssif_pkg::IRQ_W-1:0] irq_status_reg;
  logic [ssif_pkg::IRQ_W-1:0] irq_enable_reg;
  logic [ssif_pkg::IRQ_W-1:0] irq_event;

  logic wr_en;
  logic rd_hit;
  logic term_hit;
  logic [2:0] term_idx;

  // Transfers complete in the access phase with no wait state.
  assign pready = psel & penable;
  assign wr_en = psel & penable & pwrite;
  assign term_hit = (paddr[7:5] == ssif_pkg::OFS_TERM_BASE[7:5]);
  assign term_idx = paddr[4:2];

  // Decodes the address; unmapped words answer with an error.
  always_comb
  begin
    rd_hit = 1'b1;
    if (term_hit || paddr[1:0] != 2'b00)
    begin
      rd_hit = term_hit && paddr[1:0] == 2'b00;
    end
    else
    begin
      case (paddr)
        ssif_pkg::OFS_SYNC_MODE, ssif_pkg::OFS_FUNC_LATCH_TRIGGER_INPUT_2, ssif_pkg::OFS_OT_DISABLE,
        ssif_pkg::OFS_STATUS, ssif_pkg::OFS_IRQ_STATUS, ssif_pkg::OFS_IRQ_CLEAR,
        ssif_pkg::OFS_IRQ_ENABLE: rd_hit = 1'b1;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  assign pslverr = pready & ~rd_hit;

  // Settings written by software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_mode_setting_reg <= ssif_pkg::SYNC_MODE_RST;
      function_extended_setting_two_reg <= ssif_pkg::FUNC_LATCH_TRIGGER_INPUT_2_RST;
      overtravel_function_disable_reg <= ssif_pkg::OT_DISABLE_RST;
      irq_enable_reg <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        ssif_pkg::OFS_SYNC_MODE: sync_mode_setting_reg <= pwdata[15:0];
        ssif_pkg::OFS_FUNC_LATCH_TRIGGER_INPUT_2: function_extended_setting_two_reg <= pwdata[15:0];
        ssif_pkg::OFS_OT_DISABLE: overtravel_function_disable_reg <= pwdata[0];
        ssif_pkg::OFS_IRQ_ENABLE: irq_enable_reg <= pwdata[ssif_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Terminal assignments: one code per control mode, so a terminal can
  // never carry two functions in the same mode.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < N_TERM; i++)
      begin
        term_cfg_reg[i] <= ssif_pkg::TERM_RST;
      end
    end
    else if (wr_en && term_hit && paddr[1:0] == 2'b00)
    begin
      term_cfg_reg[term_idx] <= pwdata[ssif_pkg::TERM_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input noise filter.

  logic [N_TERM-1:0] term_filt;

  for (genvar t = 0; t < N_TERM; t++)
  begin : g_filt
    logic [7:0] run_reg;
    logic lvl_reg;
    // A new level is taken only after it has held for FILT cycles.
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        run_reg <= 8'h00;
        lvl_reg <= 1'b0;
      end
      else if (term_in[t] == lvl_reg)
      begin
        run_reg <= 8'h00;
      end
      else if (run_reg == 8'(FILT - 1))
      begin
        lvl_reg <= term_in[t];
        run_reg <= 8'h00;
      end
      else
      begin
        run_reg <= run_reg + 8'h01;
      end
    end
    assign term_filt[t] = lvl_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function mapping and allocation checks.

  logic [ssif_pkg::N_FN-1:0] fn_act;
  logic [3:0] fn_cnt [ssif_pkg::N_FN];
  logic alloc_dup;
  logic alloc_pair;

  // Resolves each function from the terminal that carries it this mode.
  always_comb
  begin
    logic [3:0] code;
    logic lvl;
    code = ssif_pkg::FN_NONE;
    lvl = 1'b0;
    fn_act = '0;
    for (int f = 0; f < ssif_pkg::N_FN; f++)
    begin
      fn_cnt[f] = 4'h0;
    end
    for (int i = 0; i < N_TERM; i++)
    begin
      code = ssif_pkg::FN_NONE;
      if (ctrl_mode < 2'(ssif_pkg::N_MODES))
      begin
        code = term_cfg_reg[i][ctrl_mode*ssif_pkg::TERM_FN_W +: ssif_pkg::TERM_FN_W];
      end
      // Logical state: the terminal's own logic setting undoes its wiring.
      lvl = term_filt[i] ^ term_cfg_reg[i][ssif_pkg::TERM_INV_BIT];
      if (code != ssif_pkg::FN_NONE && int'(code) < ssif_pkg::N_FN)
      begin
        fn_act[code] = fn_act[code] | lvl;
        fn_cnt[code] = fn_cnt[code] + 4'h1;
      end
    end
  end

  // Two shared-position functions, or one function twice, is an error.
  always_comb
  begin
    alloc_dup = 1'b0;
    alloc_pair = 1'b0;
    for (int f = 1; f < ssif_pkg::N_FN; f++)
    begin
      if (fn_cnt[f] > 4'h1)
      begin
        alloc_dup = 1'b1;
      end
    end
    for (int k = 0; k < 5; k++)
    begin
      if (fn_cnt[int'(ssif_pkg::FN_SMON1) + k] != 4'h0 &&
          fn_cnt[int'(ssif_pkg::FN_LATCH1) + k] != 4'h0)
      begin
        alloc_pair = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte assembly.

  logic [7:0] inputs_now;
  logic pos_ot;
  logic neg_ot;
  logic [1:0] ot_pair;

  // Overtravel bits follow the order and polarity settings, and the mute setting only while overtravel is disabled.
  always_comb
  begin
    pos_ot = fn_act[ssif_pkg::FN_POS_OT];
    neg_ot = fn_act[ssif_pkg::FN_NEG_OT];
    if (function_extended_setting_two_reg[ssif_pkg::LATCH_TRIGGER_INPUT_2_OT_SWAP_BIT])
    begin
      ot_pair = {neg_ot, pos_ot};
    end
    else
    begin
      ot_pair = {pos_ot, neg_ot};
    end
    if (function_extended_setting_two_reg[ssif_pkg::LATCH_TRIGGER_INPUT_2_OT_INV_BIT])
    begin
      ot_pair = ~ot_pair;
    end
    if (overtravel_function_disable_reg &&
        function_extended_setting_two_reg[ssif_pkg::LATCH_TRIGGER_INPUT_2_OT_MUTE_BIT])
    begin
      ot_pair = 2'b00;
    end
  end

  // Shared positions report whichever of the pair is assigned.
  always_comb
  begin
    inputs_now[7] = fn_act[int'(ssif_pkg::FN_SMON1) + 4] | fn_act[ssif_pkg::FN_ESTOP];
    inputs_now[6] = fn_act[int'(ssif_pkg::FN_SMON1) + 3] | fn_act[ssif_pkg::FN_EXT_ON];
    for (int k = 0; k < 3; k++)
    begin
      // Latch bits carry the live level, not latch completion.
      inputs_now[3 + k] = fn_act[int'(ssif_pkg::FN_SMON1) + k] |
                          fn_act[int'(ssif_pkg::FN_LATCH1) + k];
    end
    inputs_now[2] = fn_act[ssif_pkg::FN_ORIGIN];
    inputs_now[1:0] = ot_pair;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation and ready.

  logic [CNT_W-1:0] cnt_prev_reg;
  logic cnt_seen_reg;
  logic cnt_ok_reg;
  logic cnt_bad;
  logic full_sync;
  logic sync_good;
  logic ready_now;
  logic shared_now;

  assign full_sync = sync_mode_setting_reg[ssif_pkg::SYNC_FULL_BIT];
  assign cnt_bad = cyc_tick & cnt_seen_reg & full_sync &
                   (sync_cycle_counter != cnt_prev_reg + CNT_W'(1));

  // In full sync mode, checks that the host steps its counter by one each cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_prev_reg <= '0;
      cnt_seen_reg <= 1'b0;
      cnt_ok_reg <= 1'b0;
    end
    else if (cyc_tick)
    begin
      cnt_prev_reg <= sync_cycle_counter;
      cnt_seen_reg <= 1'b1;
      cnt_ok_reg <= cnt_seen_reg & ~cnt_bad;
    end
  end

  // Ready also needs the cycle ratio or counter check of the sync mode.
  always_comb
  begin
    if (full_sync)
    begin
      sync_good = cnt_ok_reg;
    end
    else
    begin
      sync_good = drive.ratio_one;
    end
    ready_now = drive.mains_ok & ~drive.alarm_active &
                drive.servo_synced & sync_good;
    if (drive.reset_busy && drive.attr_c_mode)
    begin
      ready_now = 1'b0;
    end
  end

  // The shared bit shows position generation or the mains-loss alarm.
  always_comb
  begin
    if (function_extended_setting_two_reg[ssif_pkg::LATCH_TRIGGER_INPUT_2_SHARED_SEL_BIT])
    begin
      shared_now = drive.mains_loss_alarm;
    end
    else
    begin
      shared_now = drive.pos_gen_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response sampling.

  // Captures all flags once per communication cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resp <= '0;
      resp_valid <= 1'b0;
    end
    else
    begin
      resp_valid <= cyc_tick;
      if (cyc_tick)
      begin
        resp.ready <= ready_now;
        resp.shared <= shared_now;
        resp.inputs <= inputs_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  assign irq_event[ssif_pkg::IRQ_ALLOC1] = alloc_pair;
  assign irq_event[ssif_pkg::IRQ_ALLOC2] = alloc_dup;
  assign irq_event[ssif_pkg::IRQ_SYNC] = cnt_bad;

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_reg <= '0;
    end
    else
    begin
      if (wr_en && paddr == ssif_pkg::OFS_IRQ_CLEAR)
      begin
        irq_status_reg <= (irq_status_reg & ~pwdata[ssif_pkg::IRQ_W-1:0]) | irq_event;
      end
      else
      begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Returns the addressed register; write-only and unmapped read zero.
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (term_hit)
    begin
      prdata[ssif_pkg::TERM_W-1:0] = term_cfg_reg[term_idx];
    end
    else
    begin
      case (paddr)
        ssif_pkg::OFS_SYNC_MODE: prdata[15:0] = sync_mode_setting_reg;
        ssif_pkg::OFS_FUNC_LATCH_TRIGGER_INPUT_2: prdata[15:0] = function_extended_setting_two_reg;
        ssif_pkg::OFS_OT_DISABLE: prdata[0] = overtravel_function_disable_reg;
        ssif_pkg::OFS_STATUS: prdata[9:0] = resp;
        ssif_pkg::OFS_IRQ_STATUS: prdata[ssif_pkg::IRQ_W-1:0] = irq_status_reg;
        ssif_pkg::OFS_IRQ_ENABLE: prdata[ssif_pkg::IRQ_W-1:0] = irq_enable_reg;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : ssif_flags

`default_nettype wire

// >>> verification/ssif_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ssif_host_model #(
  parameter int CNT_W = 8,
  parameter int PERIOD = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Scenario control: step the counter by two.
  input wire logic miscount,
  // Cycle start and counter towards the drive.
  output logic cyc_tick,
  output logic [CNT_W-1:0] sync_cycle_counter
);
  int unsigned phase;

  // Opens a cycle every PERIOD clocks; the counter moves with the tick.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 0;
      cyc_tick <= 1'b0;
      sync_cycle_counter <= '0;
    end
    else
    begin
      phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
      cyc_tick <= (phase == PERIOD - 1);
      if (phase == PERIOD - 1)
        sync_cycle_counter <= sync_cycle_counter + CNT_W'(miscount ? 2 : 1);
    end
  end
endmodule : ssif_host_model

`default_nettype wire

// >>> verification/ssif_flags_checker.sv
`timescale 1ns/100ps
`default_nettype none

module ssif_flags_checker #(
  parameter int N_TERM = 8,
  parameter int CNT_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Terminals and drive state.
  input wire logic [N_TERM-1:0] term_in,
  input wire logic [1:0] ctrl_mode,
  input wire ssif_pkg::ssif_drive_t drive,
  // Communication cycle.
  input wire logic cyc_tick,
  input wire logic [CNT_W-1:0] sync_cycle_counter,
  input wire ssif_pkg::ssif_resp_t resp,
  input wire logic resp_valid,
  // Interrupt.
  input wire logic irq
);
  // All checks use the bus clock and rest during reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A frame answer follows its tick by one cycle.
  sequence tick_s;
    cyc_tick;
  endsequence
  sequence answer_s;
    resp_valid;
  endsequence

  a_tick_answer: assert property (tick_s |=> answer_s)
    else $error("tick without answer");
  a_answer_cause: assert property (answer_s |-> $past(cyc_tick))
    else $error("answer without tick");
  a_resp_hold: assert property (!resp_valid |-> $stable(resp))
    else $error("response moved between frames");
  a_ready_cause: assert property (resp_valid && resp.ready |->
    $past(drive.mains_ok && !drive.alarm_active && drive.servo_synced))
    else $error("ready without its conditions");
  a_ready_reset_cmd: assert property (resp_valid &&
    $past(drive.reset_busy && drive.attr_c_mode) |-> !resp.ready)
    else $error("ready during reset command");
  a_unassigned_zero: assert property (resp_valid && $past(ctrl_mode) == 2'h3 |->
    resp.inputs[7:2] == 6'h00)
    else $error("unassigned input reported");
  a_apb_ready: assert property (pready == (psel && penable))
    else $error("pready off its access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule : ssif_flags_checker

bind ssif_flags ssif_flags_checker #(.N_TERM(N_TERM), .CNT_W(CNT_W)) ssif_flags_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .term_in(term_in), .ctrl_mode(ctrl_mode), .drive(drive), .cyc_tick(cyc_tick),
  .sync_cycle_counter(sync_cycle_counter), .resp(resp), .resp_valid(resp_valid), .irq(irq)
);

`default_nettype wire

// >>> verification/ssif_flags_test.sv
`timescale 1ns/100ps
`default_nettype none

module ssif_flags_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] term_in = 8'h00;
  logic [1:0] ctrl_mode = 2'h0;
  ssif_pkg::ssif_drive_t drv = '0;
  logic cyc_tick;
  logic [7:0] sync_cycle_counter;
  ssif_pkg::ssif_resp_t resp;
  ssif_pkg::ssif_resp_t got;
  logic resp_valid;
  logic irq;
  logic miscount = 1'b0;
  logic [31:0] rdat;
  logic err;
  logic glitch;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [3:0] code [8] = '{4'h1, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'h8};
  int bitpos [8] = '{3, 4, 6, 7, 2, 1, 0, 5};
  logic [7:0] dv [6] = '{8'hb0, 8'h30, 8'hf0, 8'ha0, 8'h90, 8'hbc};
  logic [31:0] fe [5] = '{32'h0, 32'h8, 32'h40, 32'h48, 32'h4};
  logic [7:0] ot [5] = '{8'h02, 8'h01, 8'h01, 8'h02, 8'h02};

  // Clock of 100 ns period.
  always #50 pclk = ~pclk;

  ssif_flags #(.N_TERM(8), .CNT_W(8), .FILT(ssif_pkg::FILTER_CYCLES)) ssif_flags_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .ctrl_mode(ctrl_mode), .drive(drv), .cyc_tick(cyc_tick),
    .sync_cycle_counter(sync_cycle_counter), .resp(resp), .resp_valid(resp_valid), .irq(irq)
  );

  ssif_host_model #(.CNT_W(8), .PERIOD(16)) ssif_host_model_i (
    .pclk(pclk), .presetn(presetn), .miscount(miscount), .cyc_tick(cyc_tick),
    .sync_cycle_counter(sync_cycle_counter)
  );

  ////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, s, g, e);
    end
  endtask : chk

  // One APB transfer: setup cycle, then access until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads a register and compares the masked word.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string s);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e, s);
  endtask : rd

  // Waits two answers so the frame reflects inputs set before it.
  task automatic frame;
    repeat (2)
    begin
      @(negedge pclk);
      while (resp_valid !== 1'b1)
        @(negedge pclk);
    end
    got = resp;
    @(posedge pclk);
  endtask : frame

  // Cuts a hang short.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'hffffffff, 32'h0, "sync reset");
    rd(8'h04, 32'hffffffff, 32'h0, "latch_trigger_input_2 reset");
    rd(8'h08, 32'hffffffff, 32'h0, "ot disable reset");
    rd(8'h18, 32'hffffffff, 32'h0, "irq enable reset");
    rd(8'h14, 32'hffffffff, 32'h0, "clear reads zero");
    rd(8'h20, 32'hffffffff, 32'h0, "terminal reset");
    chk(err, 1'b0, "mapped error");
    rd(8'h40, 32'hffffffff, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    apb(1'b1, 8'h02, 32'h1);
    chk(err, 1'b1, "misaligned error");
    apb(1'b1, 8'h0c, 32'h3ff);
    rd(8'h0c, 32'hffffffff, 32'h0, "status read only");
    $display("test registers done");
    for (int t = 0; t < 8; t++)
      apb(1'b1, 8'h20 + 8'(4 * t), {28'h0, code[t]});
    for (int t = 0; t < 8; t++)
    begin
      term_in <= 8'h01 << t;
      frame();
      chk(got.inputs, 32'h1 << bitpos[t], "input map");
    end
    apb(1'b1, 8'h20, 32'h1001);
    term_in <= 8'h00;
    frame();
    chk(got.inputs, 8'h08, "inverted wiring");
    apb(1'b1, 8'h20, 32'h1);
    // Pulses shorter than the filter time must never reach a frame.
    glitch = 1'b0;
    for (int i = 0; i < 42; i++)
    begin
      term_in <= {7'h00, (i % 7) < 4};
      @(negedge pclk);
      glitch = glitch | (i > 0 && resp_valid && resp.inputs[3]);
      @(posedge pclk);
    end
    chk(glitch, 1'b0, "glitch filtered");
    term_in <= 8'h20;
    $display("test input map done");
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 8'h04, fe[i]);
      frame();
      chk(got.inputs, ot[i], "overtravel");
    end
    apb(1'b1, 8'h08, 32'h1);
    frame();
    chk(got.inputs, 8'h00, "overtravel muted");
    apb(1'b1, 8'h04, 32'h0);
    frame();
    chk(got.inputs, 8'h02, "overtravel reported");
    ctrl_mode <= 2'h1;
    frame();
    chk(got.inputs, 8'h00, "other mode");
    apb(1'b1, 8'h34, 32'h50c);
    ctrl_mode <= 2'h2;
    frame();
    chk(got.inputs, 8'h80, "third mode");
    ctrl_mode <= 2'h3;
    frame();
    chk(got.inputs, 8'h00, "no functions");
    ctrl_mode <= 2'h0;
    $display("test overtravel done");
    apb(1'b1, 8'h24, 32'h6);
    apb(1'b1, 8'h14, 32'h7);
    rd(8'h10, 32'h3, 32'h1, "pair allocation");
    apb(1'b1, 8'h24, 32'h1);
    apb(1'b1, 8'h14, 32'h7);
    rd(8'h10, 32'h3, 32'h2, "double allocation");
    apb(1'b1, 8'h24, 32'h7);
    apb(1'b1, 8'h14, 32'h7);
    rd(8'h10, 32'h3, 32'h0, "allocation cleared");
    $display("test allocation done");
    for (int i = 0; i < 6; i++)
    begin
      drv <= dv[i];
      frame();
      chk(got.ready, i == 0, "ready semi sync");
    end
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h14, 32'h7);
    apb(1'b1, 8'h18, 32'h4);
    drv <= 8'ha0;
    frame();
    chk(got.ready, 1'b1, "ready full sync");
    @(negedge pclk);
    chk(irq, 1'b0, "irq quiet");
    @(posedge pclk);
    miscount <= 1'b1;
    frame();
    chk(got.ready, 1'b0, "miscount");
    @(negedge pclk);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, 8'h18, 32'h0);
    @(negedge pclk);
    chk(irq, 1'b0, "irq masked");
    @(posedge pclk);
    miscount <= 1'b0;
    frame();
    apb(1'b1, 8'h18, 32'h4);
    apb(1'b1, 8'h14, 32'h4);
    @(negedge pclk);
    chk(irq, 1'b0, "irq cleared");
    @(posedge pclk);
    $display("test ready done");
    drv <= 8'hb2;
    frame();
    chk(got.shared, 1'b1, "generation flag");
    apb(1'b1, 8'h04, 32'h100);
    frame();
    chk(got.shared, 1'b0, "alarm selected");
    drv <= 8'hb1;
    frame();
    chk(got.shared, 1'b1, "mains loss");
    rd(8'h0c, 32'h3ff, 32'h302, "status word");
    $display("test shared flag done");
    complete_run();
  end
endmodule : ssif_flags_test

`default_nettype wire
